// [pkg/vpiu_pkg.sv]
package vpiu_pkg;

   // ------------------------------------------------------------
   // source count and indices (index 0 = highest maskable priority)
   // ------------------------------------------------------------
   localparam int unsigned NUM_SRC   = 16;
   localparam int unsigned SRC_W     = 4;
   localparam int unsigned SRC_EXT0  = 0;
   localparam int unsigned SRC_EXT1  = 1;
   localparam int unsigned SRC_EXT2  = 2;
   localparam int unsigned SRC_SIO   = 3;
   localparam int unsigned SRC_TA    = 4;
   localparam int unsigned SRC_T1    = 5;
   localparam int unsigned SRC_T2    = 6;
   localparam int unsigned SRC_T3    = 7;
   localparam int unsigned SRC_T6    = 10;
   localparam int unsigned SRC_CNT0  = 11;
   localparam int unsigned SRC_CNT1  = 12;
   localparam int unsigned SRC_KEY   = 13;
   localparam int unsigned SRC_ADC   = 14;
   localparam int unsigned SRC_SPARE = 15;
   localparam int unsigned NUM_EDGE  = 5;

   // ------------------------------------------------------------
   // vectors: low byte address of each pair, high byte is low + 1
   // ------------------------------------------------------------
   localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
   localparam logic [15:0] VEC_SRC0_LO  = 16'hFFFA;
   localparam logic [15:0] VEC_STEP     = 16'h0002;
   localparam logic [15:0] VEC_BRK_LO   = 16'hFFDC;
   localparam logic [15:0] VEC_HI_OFS   = 16'h0001;

   // ------------------------------------------------------------
   // wishbone register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_REQ    = 8'h00;
   localparam logic [7:0] ADR_EN     = 8'h04;
   localparam logic [7:0] ADR_POL    = 8'h08;
   localparam logic [7:0] ADR_CTRL   = 8'h0C;
   localparam logic [7:0] ADR_STAT   = 8'h10;
   localparam logic [7:0] ADR_KEYDIR = 8'h14;

   localparam int unsigned CTRL_IFLAG  = 0;
   localparam int unsigned CTRL_SIOSEL = 1;
   localparam int unsigned CTRL_ADCSEL = 2;

   localparam logic [15:0] REQ_RST_VAL  = 16'h0000;
   localparam logic [15:0] EN_RST_VAL   = 16'h0000;
   localparam logic [4:0]  POL_RST_VAL  = 5'h00;
   localparam logic [7:0]  KDIR_RST_VAL = 8'hFF;

   typedef enum logic [1:0] {
      VPIU_IDLE,
      VPIU_WAIT_END,
      VPIU_VEC
   } vpiu_state_t;

   // grant to core: vector pair and source
   typedef struct packed {
      logic        valid;
      logic        is_reset;
      logic        is_brk;
      logic [3:0]  src;
      logic [15:0] vec_lo;
      logic [15:0] vec_hi;
   } vpiu_grant_t;

endpackage

// [hdl/vpiu_top.sv]
`timescale 1ns/1ps
// Functional notes
// - sixteen request sources, vectored, fixed hardware priority order.
// - simultaneous pending requests: higher priority granted first.
// - per-source enable bits plus global disable flag mask maskable requests.
// - reset is top priority, vector pair FFFD/FFFC.
// - edge input zero, selectable edge, priority 2, vector FFFB/FFFA.
// - edge input one, selectable edge, priority 3, vector FFF9/FFF8.
// - edge input two, selectable edge, priority 4, vector FFF7/FFF6.
// - serial completion request priority 5, only when serial selected, FFF5/FFF4.
// - sixteen-bit timer underflow, priority 6, vector FFF3/FFF2.
// - timer one underflow, priority 7, vector FFF1/FFF0.
// - timer two underflow, priority 8, FFEF/FFEE, ends stop wait.
// - timers three to six, priorities 9-12, vectors FFED/FFEC to FFE7/FFE6.
// - counter pins zero/one, selectable edge, priorities 13/14, FFE5 and FFE3.
// - key port falling AND of input lines, priority 15, FFE1/FFE0.
// - converter completion, priority 16 when selected, vector FFDF/FFDE.
// - break instruction is non-maskable, served after reset but before every maskable source, vector FFDD/FFDC.
// - vector pair holds routine start address loaded into program counter.
// - servicing starts the machine cycle after current instruction ends.
// - request flag writes take effect one instruction later.
// - global disable flag reads set after reset.
module vpiu_top
   import vpiu_pkg::*;
#(
   parameter int unsigned KEY_W = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone classic slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // request sources
   input  wire logic              ext_edge_irq_zero_i,
   input  wire logic              ext_edge_irq_one_i,
   input  wire logic              ext_edge_irq_two_i,
   input  wire logic              counter_pin_zero_i,
   input  wire logic              counter_pin_one_i,
   input  wire logic [KEY_W-1:0]  key_input_port_i,
   input  wire logic              sio_done_i,
   input  wire logic              timer_a_uflow_i,
   input  wire logic [5:0]        timer_uflow_i,
   input  wire logic              adc_done_i,
   // processor core side
   input  wire logic              instr_end_i,
   input  wire logic              software_break_instr_i,
   input  wire logic              grant_ack_i,
   input  wire logic              stop_oscillator_instr_i,
   output vpiu_grant_t            grant_o,
   output logic                   iflag_o,
   output logic                   stop_wait_o
);

   // key direction reset value is one byte wide
   generate
      if (KEY_W < 1 || KEY_W > 8) begin : g_bad_key_w
         $error("KEY_W must be 1..8");
      end
   endgenerate

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0]      req_ff;
   logic [15:0]      en_ff;
   logic [4:0]       pol_ff;
   logic             iflag_ff;
   logic             siosel_ff;
   logic             adcsel_ff;
   logic [KEY_W-1:0] keydir_ff;
   logic [15:0]      wr_req_ff;
   logic             wr_pend_ff;
   logic             ack_ff;
   logic [31:0]      rdat_ff;
   logic             stop_ff;
   vpiu_state_t      state_ff;
   vpiu_grant_t      grant_ff;
   logic             rst_seen_ff;
   logic             brk_pend_ff;
   logic [4:0]       edge_prev_ff;
   logic             key_prev_ff;

   logic             wb_req;
   logic             wr_req;
   logic             wr_en;
   logic             wr_ctrl;
   logic [15:0]      set_vec;
   logic [15:0]      eligible;
   logic             any_elig;
   logic [3:0]       win_src;
   logic             take;
   logic [4:0]       edge_now;
   logic [4:0]       edge_hit;
   logic             key_and;
   logic [15:0]      clr_vec;
   logic             grant_any;
   logic [15:0]      src_vec_lo;

   assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_req  = wb_req & wb_we_i & (wb_adr_i == ADR_REQ);
   assign wr_en   = wb_req & wb_we_i & (wb_adr_i == ADR_EN);
   assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == ADR_CTRL);

   // ------------------------------------------------------------
   // source event detection
   // ------------------------------------------------------------
   assign edge_now = {counter_pin_one_i, counter_pin_zero_i, ext_edge_irq_two_i,
                      ext_edge_irq_one_i, ext_edge_irq_zero_i};
   // pol bit 1 = rising edge, 0 = falling edge
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EDGE; gi++) begin : g_edge
         assign edge_hit[gi] = pol_ff[gi] ? (edge_now[gi] & ~edge_prev_ff[gi])
                                          : (~edge_now[gi] & edge_prev_ff[gi]);
      end
   endgenerate

   // output-configured key lines read as one so they do not affect the and
   assign key_and = &(key_input_port_i | ~keydir_ff);

   always_comb begin
      set_vec = '0;
      set_vec[SRC_EXT0] = edge_hit[0];
      set_vec[SRC_EXT1] = edge_hit[1];
      set_vec[SRC_EXT2] = edge_hit[2];
      set_vec[SRC_SIO]  = sio_done_i & siosel_ff;
      set_vec[SRC_TA]   = timer_a_uflow_i;
      set_vec[SRC_T1]   = timer_uflow_i[0];
      set_vec[SRC_T2]   = timer_uflow_i[1];
      set_vec[SRC_T6:SRC_T3] = timer_uflow_i[5:2];
      set_vec[SRC_CNT0] = edge_hit[3];
      set_vec[SRC_CNT1] = edge_hit[4];
      set_vec[SRC_KEY]  = key_prev_ff & ~key_and;
      set_vec[SRC_ADC]  = adc_done_i & adcsel_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_prev_ff <= '0;
         key_prev_ff  <= 1'b0;
      end else begin
         edge_prev_ff <= edge_now;
         key_prev_ff  <= key_and;
      end
   end

   // ------------------------------------------------------------
   // priority selection
   // ------------------------------------------------------------
   // the spare index has no vector of its own and is never granted
   assign eligible = req_ff & en_ff & {NUM_SRC{~iflag_ff}}
                   & ~(16'h0001 << SRC_SPARE);

   always_comb begin
      win_src  = '0;
      any_elig = 1'b0;
      // lowest index wins: fixed priority
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            win_src  = 4'(i);
            any_elig = 1'b1;
         end
      end
   end

   // grant taken at end of instruction only
   assign take = (state_ff == VPIU_WAIT_END) & instr_end_i;
   // reset and break bypass the mask; a take with neither and no eligible request grants nothing
   assign grant_any = rst_seen_ff | brk_pend_ff | any_elig;

   // routine start pair of the winning maskable source
   assign src_vec_lo = VEC_SRC0_LO - 16'(VEC_STEP * win_src);

   always_comb begin
      clr_vec = '0;
      if (take && !rst_seen_ff && !brk_pend_ff && any_elig) begin
         clr_vec[win_src] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // request flags; hardware set beats clears, sw write delayed
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_req_ff  <= REQ_RST_VAL;
         wr_pend_ff <= 1'b0;
      end else begin
         // events while a write waits are kept: hardware set wins
         if (wr_req) begin
            wr_req_ff  <= wb_dat_i[15:0] | set_vec;
            wr_pend_ff <= 1'b1;
         end else if (instr_end_i) begin
            wr_pend_ff <= 1'b0;
         end else if (wr_pend_ff) begin
            wr_req_ff <= wr_req_ff | set_vec;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_ff <= REQ_RST_VAL;
      end else if (wr_pend_ff && instr_end_i) begin
         req_ff <= (wr_req_ff & ~clr_vec) | set_vec;
      end else begin
         req_ff <= (req_ff & ~clr_vec) | set_vec;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff     <= EN_RST_VAL;
         pol_ff    <= POL_RST_VAL;
         siosel_ff <= 1'b0;
         adcsel_ff <= 1'b0;
         keydir_ff <= KDIR_RST_VAL[KEY_W-1:0];
      end else if (wb_req && wb_we_i) begin
         if (wr_en) begin
            en_ff <= wb_dat_i[15:0];
         end else if (wb_adr_i == ADR_POL) begin
            pol_ff <= wb_dat_i[4:0];
         end else if (wb_adr_i == ADR_CTRL) begin
            siosel_ff <= wb_dat_i[CTRL_SIOSEL];
            adcsel_ff <= wb_dat_i[CTRL_ADCSEL];
         end else if (wb_adr_i == ADR_KEYDIR) begin
            keydir_ff <= wb_dat_i[KEY_W-1:0];
         end
      end
   end

   // any grant (reset, break or maskable request) sets flag; beats a sw write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iflag_ff <= 1'b1;
      end else if (take && grant_any) begin
         iflag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         iflag_ff <= wb_dat_i[CTRL_IFLAG];
      end
   end

   // ------------------------------------------------------------
   // reset and break capture
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_seen_ff <= 1'b1;
         brk_pend_ff <= 1'b0;
      end else begin
         if (take) begin
            rst_seen_ff <= 1'b0;
         end
         if (software_break_instr_i) begin
            brk_pend_ff <= 1'b1;
         end else if (take && !rst_seen_ff) begin
            brk_pend_ff <= 1'b0;
         end
      end
   end

   // stop wait ends on timer two underflow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_ff <= 1'b0;
      end else if (timer_uflow_i[1]) begin
         stop_ff <= 1'b0;
      end else if (stop_oscillator_instr_i) begin
         stop_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // grant sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= VPIU_WAIT_END;
      end else begin
         case (state_ff)
            VPIU_IDLE: begin
               if (any_elig || brk_pend_ff || software_break_instr_i) begin
                  state_ff <= VPIU_WAIT_END;
               end
            end
            VPIU_WAIT_END: begin
               if (take) begin
                  state_ff <= (rst_seen_ff || brk_pend_ff || any_elig) ? VPIU_VEC
                                                                        : VPIU_IDLE;
               end
            end
            VPIU_VEC: begin
               if (grant_ack_i) begin
                  state_ff <= VPIU_IDLE;
               end
            end
            default: state_ff <= VPIU_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grant_ff <= '0;
      end else if (take) begin
         grant_ff.valid    <= rst_seen_ff | brk_pend_ff | any_elig;
         grant_ff.is_reset <= rst_seen_ff;
         grant_ff.is_brk   <= ~rst_seen_ff & brk_pend_ff;
         grant_ff.src      <= win_src;
         if (rst_seen_ff) begin
            grant_ff.vec_lo <= VEC_RESET_LO;
            grant_ff.vec_hi <= VEC_RESET_LO + VEC_HI_OFS;
         end else if (brk_pend_ff) begin
            grant_ff.vec_lo <= VEC_BRK_LO;
            grant_ff.vec_hi <= VEC_BRK_LO + VEC_HI_OFS;
         end else begin
            // pair address for routine start, loaded into pc by core
            grant_ff.vec_lo <= src_vec_lo;
            grant_ff.vec_hi <= src_vec_lo + VEC_HI_OFS;
         end
      end else if (state_ff == VPIU_VEC && grant_ack_i) begin
         grant_ff.valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // wishbone read and ack
   // ------------------------------------------------------------
   // ack follows the taking edge by one cycle and drops by itself
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff  <= 1'b0;
         rdat_ff <= '0;
      end else begin
         ack_ff <= wb_req;
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == ADR_REQ) begin
               rdat_ff <= {16'h0000, req_ff};
            end else if (wb_adr_i == ADR_EN) begin
               rdat_ff <= {16'h0000, en_ff};
            end else if (wb_adr_i == ADR_POL) begin
               rdat_ff <= {27'h000_0000, pol_ff};
            end else if (wb_adr_i == ADR_CTRL) begin
               rdat_ff <= {29'h0000_0000, adcsel_ff, siosel_ff, iflag_ff};
            end else if (wb_adr_i == ADR_STAT) begin
               // status: stop wait, grant valid, sequencer state, winning source
               rdat_ff <= {24'h00_0000, stop_ff, grant_ff.valid, 2'(state_ff), win_src};
            end else if (wb_adr_i == ADR_KEYDIR) begin
               rdat_ff <= 32'(keydir_ff);
            end else begin
               rdat_ff <= 32'h0000_0000;
            end
         end
      end
   end

   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = rdat_ff;
   assign grant_o     = grant_ff;
   assign iflag_o     = iflag_ff;
   assign stop_wait_o = stop_ff;

endmodule

// [tb/vpiu_chk.sv]
`timescale 1ns/1ps
module vpiu_chk
   import vpiu_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        instr_end_i,
   input wire logic        grant_ack_i,
   input wire logic        stop_oscillator_instr_i,
   input wire logic [5:0]  timer_uflow_i,
   input wire vpiu_grant_t grant_o,
   input wire logic        iflag_o,
   input wire logic        stop_wait_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_vec_pair: assert property (grant_o.valid |->
      grant_o.vec_hi == grant_o.vec_lo + 16'h0001) else $error("vector pair split");
   chk_src_vec: assert property (
      grant_o.valid && !grant_o.is_reset && !grant_o.is_brk |->
      grant_o.vec_lo == 16'hFFFA - {11'h000, grant_o.src, 1'b0}) else $error("bad vector");
   chk_reset_vec: assert property (grant_o.valid && grant_o.is_reset |->
      grant_o.vec_lo == 16'hFFFC) else $error("bad reset vector");
   chk_brk_vec: assert property (grant_o.valid && grant_o.is_brk |->
      grant_o.vec_lo == 16'hFFDC) else $error("bad break vector");
   chk_after_end: assert property ($rose(grant_o.valid) |->
      $past(instr_end_i)) else $error("grant inside an instruction");
   chk_grant_hold: assert property (grant_o.valid && !grant_ack_i |=>
      grant_o.valid && $stable(grant_o.vec_lo)) else $error("grant dropped early");
   chk_grant_iflag: assert property ($rose(grant_o.valid) |-> iflag_o)
      else $error("grant left flag clear");
   chk_iflag_rst: assert property ($past(rst_i) |-> iflag_o)
      else $error("flag clear after reset");
   chk_stop_end: assert property (
      stop_wait_o && timer_uflow_i[1] && !stop_oscillator_instr_i |=> !stop_wait_o)
      else $error("stop wait not ended");
   chk_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus not answered");
endmodule

// [tb/vpiu_core_model.sv]
`timescale 1ns/1ps
module vpiu_core_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   input  wire logic grant_vld_i,
   output logic      instr_end_o,
   output logic      grant_ack_o
);
   logic [1:0] phase_ff;
   logic [2:0] wait_ff;

   // ------------------------------------------------------------
   // every fourth cycle ends an instruction
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_ff    <= 2'h0;
         instr_end_o <= 1'b0;
      end else begin
         phase_ff    <= phase_ff + 2'h1;
         instr_end_o <= (phase_ff == 2'h2);
      end
   end

   // ------------------------------------------------------------
   // vector load, short or long, then one acknowledge pulse
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !grant_vld_i || grant_ack_o) begin
         wait_ff     <= 3'h0;
         grant_ack_o <= 1'b0;
      end else begin
         wait_ff     <= wait_ff + 3'h1;
         grant_ack_o <= (wait_ff == (slow_i ? 3'h5 : 3'h1));
      end
   end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
   import vpiu_pkg::*;
;
   logic        clk_i, rst_i, cyc, stb, we, slow, wb_ack_o, iflag_o, stop_wait_o, iend, gack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rd, wb_dat_o, lfsr;
   logic [16:0] src_v;
   vpiu_grant_t grant_o;
   int          miscompares, total_checks, a, b, q[$];
   logic [7:0]  radr [5] = '{ADR_EN, ADR_POL, ADR_REQ, ADR_KEYDIR, 8'h3C};
   logic [31:0] rexp [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_00FF,
                             32'h0000_0000};

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   vpiu_top uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_edge_irq_zero_i(src_v[0]), .ext_edge_irq_one_i(src_v[1]),
      .ext_edge_irq_two_i(src_v[2]), .counter_pin_zero_i(src_v[11]),
      .counter_pin_one_i(src_v[12]), .key_input_port_i(8'hFF ^ {7'h00, src_v[13]}),
      .sio_done_i(src_v[3]), .timer_a_uflow_i(src_v[4]), .timer_uflow_i(src_v[10:5]),
      .adc_done_i(src_v[14]), .instr_end_i(iend), .software_break_instr_i(src_v[15]),
      .grant_ack_i(gack), .stop_oscillator_instr_i(src_v[16]), .grant_o(grant_o),
      .iflag_o(iflag_o), .stop_wait_o(stop_wait_o));

   vpiu_core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .grant_vld_i(grant_o.valid), .instr_end_o(iend), .grant_ack_o(gack));

   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic hang;
      miscompares++;
      $display("ERROR %0t wait ran out", $time);
      wrap_up();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      lfsr = lfsr_step(lfsr);
      {cyc, stb, we, adr, wdat, sel, slow} <= {2'b11, w, ad, d, lfsr[3:0], lfsr[5]};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
         hang();
      rd = wb_dat_o;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask

   task automatic fire(input int i);
      src_v[i] <= 1'b1;
      @(posedge clk_i);
      src_v[i] <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   // kind: 0 maskable source i, 1 reset, 2 break
   task automatic expect_grant(input int i, input int kind);
      int n;
      logic [15:0] v;
      v = (kind == 1) ? 16'hFFFC : (kind == 2) ? 16'hFFDC : 16'hFFFA - 16'(2 * i);
      n = 0;
      while (grant_o.valid !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300)
         hang();
      check({grant_o.vec_hi, grant_o.vec_lo}, {v + 16'h0001, v});
      check({grant_o.is_reset, grant_o.is_brk}, {kind == 1, kind == 2});
      if (kind == 0)
         check(grant_o.src, i[3:0]);
      check(iflag_o, 1'b1);
      n = 0;
      while (grant_o.valid !== 1'b0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50)
         hang();
      $display("grant %0d kind %0d done", i, kind);
   endtask

   initial begin
      {rst_i, cyc, stb, we, adr, wdat, sel, slow, src_v} = '0;
      rst_i = 1'b1;
      lfsr = 32'h89d9_0492;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      expect_grant(0, 1);
      wb(1'b1, 8'h3C, 32'h0000_FFFF);
      foreach (radr[j]) begin
         wb(1'b0, radr[j], 32'h0000_0000);
         check(rd, rexp[j]);
      end
      wb(1'b0, ADR_CTRL, 32'h0000_0000);
      check(rd[0], 1'b1);
      $display("reset test done");
      // ------------------------------------------------------------
      // sources 0 to 14 alone, rising edges selected
      // ------------------------------------------------------------
      wb(1'b1, ADR_POL, 32'h0000_001F);
      wb(1'b1, ADR_EN, 32'h0000_FFFF);
      for (int i = 0; i < 15; i++) begin
         wb(1'b1, ADR_CTRL, 32'h0000_0006);
         fire(i);
         expect_grant(i, 0);
      end
      $display("source test done");
      // ------------------------------------------------------------
      // masked source and unselected serial stay silent
      // ------------------------------------------------------------
      wb(1'b1, ADR_EN, 32'h0000_FFDF);
      wb(1'b1, ADR_CTRL, 32'h0000_0004);
      fire(5);
      fire(3);
      idle(20);
      check(grant_o.valid, 1'b0);
      wb(1'b1, ADR_EN, 32'h0000_FFFF);
      expect_grant(5, 0);
      $display("mask test done");
      // ------------------------------------------------------------
      // random pairs pending together
      // ------------------------------------------------------------
      for (int k = 0; k < 6; k++) begin
         // keep the flag set while both sources fire, with both selects on
         wb(1'b1, ADR_CTRL, 32'h0000_0007);
         lfsr = lfsr_step(lfsr);
         a = lfsr % 15;
         b = (a + 1 + (lfsr[11:8] % 14)) % 15;
         q = '{a, b};
         q.sort();
         fire(a);
         fire(b);
         repeat (2) begin
            wb(1'b1, ADR_CTRL, 32'h0000_0006);
            expect_grant(q.pop_front(), 0);
         end
      end
      $display("pair test done");
      // ------------------------------------------------------------
      // break with flag set, then stop wait
      // ------------------------------------------------------------
      fire(15);
      expect_grant(0, 2);
      fire(16);
      check(stop_wait_o, 1'b1);
      wb(1'b0, ADR_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      fire(6);
      check(stop_wait_o, 1'b0);
      $display("stop test done");
      // ------------------------------------------------------------
      // request write lands one instruction later, then is granted
      // ------------------------------------------------------------
      wb(1'b1, ADR_REQ, 32'h0000_0010);
      idle(8);
      wb(1'b0, ADR_REQ, 32'h0000_0000);
      check(rd, 32'h0000_0010);
      wb(1'b1, ADR_CTRL, 32'h0000_0006);
      expect_grant(4, 0);
      $display("flag write test done");
      // ------------------------------------------------------------
      // falling edge selected: only the return to low requests
      // ------------------------------------------------------------
      wb(1'b1, ADR_POL, 32'h0000_0000);
      fire(0);
      wb(1'b1, ADR_CTRL, 32'h0000_0006);
      expect_grant(0, 0);
      $display("edge test done");
      wrap_up();
   end
endmodule

bind vpiu_top vpiu_chk chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .instr_end_i(instr_end_i), .grant_ack_i(grant_ack_i),
   .stop_oscillator_instr_i(stop_oscillator_instr_i), .timer_uflow_i(timer_uflow_i),
   .grant_o(grant_o), .iflag_o(iflag_o), .stop_wait_o(stop_wait_o));
